// ==== common/led_dim_pkg.sv ====
// Shared constants and carrier types for the LED string dimming block
package led_dim_pkg;
  localparam int NUM_STR = 6;
  localparam int DUTY_W = 8;
  localparam int CLK_HZ = 25_000_000;
  // Dimming period count, default about 1 kHz at 25 MHz
  localparam logic [19:0] DIM_PERIOD_CYC_RST = 20'h061A8;
  // Sustained over-current: flagged for this many ns of consecutive cycles latches a fault
  localparam int OC_SUSTAIN_NS = 10_000;
  localparam logic [15:0] OC_SUSTAIN_CYC = 16'((OC_SUSTAIN_NS * (CLK_HZ / 1_000_000)) / 1000);
  // Start-up channel scan time
  localparam int SCAN_NS = 2_000;
  localparam logic [15:0] SCAN_CYC = 16'((SCAN_NS * (CLK_HZ / 1_000_000)) / 1000);
  localparam logic [DUTY_W-1:0] DUTY_RST = 8'h00;

  typedef struct packed {
    logic [NUM_STR-1:0] open_str;
    logic [NUM_STR-1:0] ov_str;
    logic cycle_ilim;
    logic out_short;
    logic over_temp;
  } fault_flags_t;

  typedef enum logic [1:0] {ST_OFF, ST_SCAN, ST_RUN, ST_FAULT} run_state_t;
endpackage

// ==== hw/sync2.sv ====
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ==== hw/led_dim_ctrl.sv ====
// Dimming engine, duty decoder and fault latches of the LED string driver
`timescale 1ns/10ps
module led_dim_ctrl
  import led_dim_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic ENABLE_I,
  input wire logic DIM_FREQ_MODE_STRAP_I,
  input wire logic [19:0] DIM_PERIOD_CYC_I,
  input wire logic BRIGHT_PWM_I,
  input wire logic SW_CYCLE_START_I,
  input wire led_dim_pkg::fault_flags_t FAULT_FLAGS_I,
  output logic [led_dim_pkg::NUM_STR-1:0] SINK_ON_O,
  output logic [led_dim_pkg::NUM_STR-1:0] STRING_ACTIVE_O,
  output logic BOOST_SW_EN_O,
  output logic [led_dim_pkg::DUTY_W-1:0] DUTY_CODE_O,
  output logic DIRECT_MODE_O,
  output logic DEVICE_RUN_O
);
  import led_dim_pkg::*;

  fault_flags_t flt;
  logic [2:0] pin_s;
  logic en_s, strap_s, pwm_s, pwm_d_q;
  run_state_t state_q;
  logic direct_q;
  logic [NUM_STR-1:0] used_q, off_q;
  logic [15:0] scan_cnt_q, oc_cnt_q;
  logic [31:0] hi_cnt_q, per_cnt_q;
  logic [DUTY_W-1:0] code_q;
  logic [19:0] per_q, ph_cnt_q;
  logic ilim_q, shut_q;
  logic [2:0] n_used;
  logic [DUTY_W-1:0] meas;
  logic rise, running, fatal;

  // Pins and analog flags are asynchronous to CLK_I
  sync2 #(.W(3)) u_pin_sync (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .d_i({ENABLE_I, DIM_FREQ_MODE_STRAP_I, BRIGHT_PWM_I}), .q_o(pin_s));
  sync2 #(.W($bits(fault_flags_t))) u_flt_sync (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .d_i(FAULT_FLAGS_I), .q_o(flt));
  assign en_s = pin_s[2];
  assign strap_s = pin_s[1];
  assign pwm_s = pin_s[0];
  assign rise = pwm_s & ~pwm_d_q;
  assign running = (state_q == ST_RUN);
  assign fatal = (&off_q) | flt.out_short | flt.over_temp | (oc_cnt_q >= OC_SUSTAIN_CYC);

  // Run sequencing; enable low clears the fault state and string latches, but not ilim_q
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= ST_OFF;
      scan_cnt_q <= '0;
    end else if (!en_s) begin
      state_q <= ST_OFF;
      scan_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_OFF: state_q <= ST_SCAN;
        ST_SCAN: begin
          scan_cnt_q <= scan_cnt_q + 16'h0001;
          if (scan_cnt_q >= SCAN_CYC - 16'h0001) state_q <= ST_RUN;
        end
        ST_RUN: if (fatal) state_q <= ST_FAULT;
        ST_FAULT: state_q <= ST_FAULT;
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // Mode and period caught at scan, held while running
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      direct_q <= 1'b0;
      per_q <= DIM_PERIOD_CYC_RST;
    end else if (state_q == ST_SCAN) begin
      direct_q <= strap_s;
      per_q <= (DIM_PERIOD_CYC_I == 20'h00000) ? DIM_PERIOD_CYC_RST : DIM_PERIOD_CYC_I;
    end
  end

  // Used channel map and sticky string disables
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      used_q <= '0;
      off_q <= '0;
    end else if (!en_s) begin
      used_q <= '0;
      off_q <= '0;
    end else if (state_q == ST_SCAN) begin
      used_q <= ~flt.open_str;
      off_q <= flt.open_str;
    end else if (running) begin
      off_q <= off_q | flt.open_str | flt.ov_str;
    end
  end

  // Sustained over-current counter
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) oc_cnt_q <= '0;
    else if (!running || !flt.cycle_ilim) oc_cnt_q <= '0;
    else if (oc_cnt_q < OC_SUSTAIN_CYC) oc_cnt_q <= oc_cnt_q + 16'h0001;
  end

  // Pulse-by-pulse limit holds switch off until next cycle start
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) ilim_q <= 1'b0;
    else if (flt.cycle_ilim) ilim_q <= 1'b1;
    else if (SW_CYCLE_START_I) ilim_q <= 1'b0;
  end

  // Input duty measurement over one input period, rising to rising
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pwm_d_q <= 1'b0;
      hi_cnt_q <= '0;
      per_cnt_q <= '0;
    end else begin
      pwm_d_q <= pwm_s;
      if (direct_q || !running || rise) begin
        hi_cnt_q <= {31'h0, rise & ~direct_q};
        per_cnt_q <= {31'h0, rise & ~direct_q};
      end else begin
        per_cnt_q <= per_cnt_q + 32'h1;
        if (pwm_s) hi_cnt_q <= hi_cnt_q + 32'h1;
      end
    end
  end

  // Quantise high time to 8 bits
  always_comb begin
    logic [39:0] prod;
    prod = {hi_cnt_q, 8'h00};
    meas = (per_cnt_q == 32'h0) ? code_q : 8'((prod - {8'h00, hi_cnt_q}) / {8'h00, per_cnt_q});
  end

  // Stored code with one LSB hysteresis
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) code_q <= DUTY_RST;
    else if (running && !direct_q && rise && per_cnt_q != 32'h0) begin
      if (meas > code_q) code_q <= meas;
      // Widened compare so a full-scale reading cannot wrap to zero
      else if ({1'b0, meas} + 9'h001 < {1'b0, code_q}) code_q <= meas + 8'h01;
    end
  end

  // Free-running dimming period counter
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) ph_cnt_q <= '0;
    else if (!running || ph_cnt_q >= per_q - 20'h00001) ph_cnt_q <= '0;
    else ph_cnt_q <= ph_cnt_q + 20'h00001;
  end

  // Per-channel staggered regeneration
  always_comb begin
    n_used = '0;
    for (int i = 0; i < NUM_STR; i++) n_used = n_used + 3'(used_q[i]);
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    logic [2:0] rank;
    logic [27:0] on_len, offs, pos;
    if (!RST_N_I) begin
      SINK_ON_O <= '0;
    end else begin
      rank = '0;
      on_len = 28'(({8'h00, per_q} * {20'h00000, code_q}) >> 8);
      for (int i = 0; i < NUM_STR; i++) begin
        offs = (n_used == 3'd0) ? 28'h0 : 28'(({8'h00, per_q} * {25'h0, rank}) / {25'h0, n_used});
        pos = {8'h00, ph_cnt_q} + {8'h00, per_q} - offs;
        if (pos >= {8'h00, per_q}) pos = pos - {8'h00, per_q};
        if (!running || off_q[i] || !used_q[i]) SINK_ON_O[i] <= 1'b0;
        else if (direct_q) SINK_ON_O[i] <= pwm_s;
        else SINK_ON_O[i] <= (pos < on_len);
        rank = rank + 3'(used_q[i]);
      end
    end
  end

  // Fault shutdown flag and status outputs
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) shut_q <= 1'b1;
    else shut_q <= !running || fatal;
  end

  assign BOOST_SW_EN_O = !shut_q && !ilim_q;
  assign STRING_ACTIVE_O = used_q & ~off_q;
  assign DUTY_CODE_O = code_q;
  assign DIRECT_MODE_O = direct_q;
  assign DEVICE_RUN_O = running;

  sequence s_fatal_seen;
    running && (flt.out_short || flt.over_temp);
  endsequence

  AST_FATAL_LATCH: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_fatal_seen |=> (state_q == ST_FAULT) [*2] or !en_s) else $error("fatal fault not latched");
  AST_STICKY_OFF: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (off_q[0] && en_s) |=> off_q[0]) else $error("string disable not sticky");
  AST_FORCED_OFF: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $past(off_q[1]) |-> !SINK_ON_O[1]) else $error("disabled string driven");
  AST_ILIM: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    flt.cycle_ilim |=> !BOOST_SW_EN_O) else $error("switch not off at limit");
  AST_DIRECT: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (running && direct_q && used_q[2] && !off_q[2]) |=> SINK_ON_O[2] == $past(pwm_s)) else $error("direct mismatch");
  AST_HYST: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (code_q < $past(code_q)) |-> ({1'b0, $past(meas)} + 9'h002 <= {1'b0, $past(code_q)})
    && (code_q == $past(meas) + 8'h01)) else $error("one-step fall accepted");
  AST_DECODE_OFF: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (direct_q && $past(direct_q)) |-> per_cnt_q == 32'h0) else $error("decoder active in direct");
  AST_ALL_OPEN: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (running && &off_q && en_s) |=> state_q == ST_FAULT) else $error("all open not shut down");
endmodule

// ==== verif/pwm_host.sv ====
// Host brightness PWM source with settable period and high time
`timescale 1ns/10ps
module pwm_host (
  input wire logic clk_i,
  input wire logic [15:0] per_i,
  input wire logic [15:0] hi_i,
  output logic pwm_o
);
  logic [15:0] cnt_q = 16'h0000;
  logic [15:0] hi_q = 16'h0000;
  initial pwm_o = 1'b0;
  // Stepped on the falling edge so the block never samples mid-change
  // High time taken only at period start, so no period is cut or doubled
  always @(negedge clk_i) begin
    cnt_q <= (cnt_q + 16'h0001 >= per_i) ? 16'h0000 : cnt_q + 16'h0001;
    hi_q <= (cnt_q == 16'h0000) ? hi_i : hi_q;
    pwm_o <= (cnt_q < ((cnt_q == 16'h0000) ? hi_i : hi_q));
  end
endmodule

// ==== verif/led_string_dimming_and_fault_control_test.sv ====
// Bench for the LED string dimming and fault logic
`timescale 1ns/10ps
module led_string_dimming_and_fault_control_test;
  import led_dim_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic strap = 1'b0;
  logic swc = 1'b0;
  logic [15:0] per = 16'h0014;
  logic [15:0] hi = 16'h0005;
  logic pwm, dir_mode, run, sw_en;
  logic [5:0] sink, act;
  logic [7:0] code;
  logic [1:0] h = 2'h0;
  logic chk_dir = 1'b0;
  fault_flags_t ff = '0;
  int failures = 0, checks_done = 0, m = 0, e = 0, b, n;
  int dl[4] = '{0, 1, 0, -1};
  always #20 clk = ~clk;
  pwm_host u_host (.clk_i(clk), .per_i(per), .hi_i(hi), .pwm_o(pwm));
  led_dim_ctrl u_dut (.CLK_I(clk), .RST_N_I(rst_n), .ENABLE_I(en), .DIM_FREQ_MODE_STRAP_I(strap),
    .DIM_PERIOD_CYC_I(20'h00200), .BRIGHT_PWM_I(pwm), .SW_CYCLE_START_I(swc), .FAULT_FLAGS_I(ff),
    .SINK_ON_O(sink), .STRING_ACTIVE_O(act), .BOOST_SW_EN_O(sw_en), .DUTY_CODE_O(code),
    .DIRECT_MODE_O(dir_mode), .DEVICE_RUN_O(run));
  // Switching cycle start every eighth cycle
  always @(negedge clk) swc <= (m++ % 8 == 0);
  // Direct mode: sinks repeat the input three cycles on
  always @(negedge clk) begin
    if (chk_dir) chk("sink", 16'({6{h[1]}}), 16'(sink));
    h <= {h[0], pwm};
  end
  task automatic chk(string nm, logic [15:0] ex, logic [15:0] g);
    checks_done++;
    if (g !== ex) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, ex, g);
    end
  endtask
  task automatic stop_test;
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait for the run state
  task automatic wait_run;
    n = 0;
    while (run !== 1'b1) begin
      @(negedge clk);
      if (++n > 200) begin
        failures++;
        stop_test();
      end
    end
  endtask
  task automatic boot(logic s, logic [5:0] o);
    @(negedge clk);
    rst_n = 1'b0;
    strap = s;
    ff.open_str = o;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    wait_run();
    ff.open_str = 6'h00;
  endtask
  // On cycles of one sink over one dimming period
  task automatic count(int k);
    n = 0;
    repeat (512) begin
      @(negedge clk);
      n += int'(sink[k]);
    end
  endtask
  // Cycles where sink k, shifted back by dly, differs from lowest used sink
  task automatic phase_chk(int k, int dly);
    logic [511:0] a0, a1;
    n = 0;
    for (int t = 0; t < 512; t++) begin
      @(negedge clk);
      a0[t] = sink[1];
      a1[t] = sink[k];
    end
    for (int t = 0; t < 512; t++) n += int'(a1[(t + dly) % 512] != a0[t]);
  endtask
  initial begin
    void'($urandom(32'hCD87));
    boot(1'b1, 6'h00);
    chk("mode", 16'h0001, 16'(dir_mode));
    hi = 16'($urandom_range(19, 1));
    repeat (10) @(negedge clk);
    chk_dir = 1'b1;
    repeat (100) @(negedge clk);
    chk_dir = 1'b0;
    chk("code", 16'h0000, 16'(code));
    // Zero high time first, so no stale code survives the mode change
    per = 16'h00FF;
    hi = 16'h0000;
    boot(1'b0, 6'h05);
    chk("mode", 16'h0000, 16'(dir_mode));
    chk("active", 16'h003A, 16'(act));
    b = $urandom_range(200, 20);
    // Period 255 makes the measured code equal the high time
    for (int i = 0; i < 6; i++) begin
      hi = 16'((i < 4) ? b + dl[i] : $urandom_range(250, 3));
      repeat (1100) @(negedge clk);
      if (hi > e) e = hi;
      else if (hi + 1 < e) e = hi + 1;
      chk("code", 16'(e), 16'(code));
      count(1);
      chk("ontime", 16'(2 * e), 16'(n));
    end
    // Four used sinks over 512 cycles: ranks 1 and 3 lag by 128 and 384
    phase_chk(3, 128);
    chk("phase3", 16'h0000, 16'(n));
    phase_chk(5, 384);
    chk("phase5", 16'h0000, 16'(n));
    ff.ov_str[3] = 1'b1;
    repeat (5) @(negedge clk);
    ff.ov_str[3] = 1'b0;
    repeat (10) @(negedge clk);
    chk("active", 16'h0032, 16'(act));
    count(3);
    chk("ovsink", 16'h0000, 16'(n));
    chk("run", 16'h0001, 16'(run));
    // Latched faults: current limit, short, heat, all strings open
    for (int i = 0; i < 4; i++) begin
      ff.cycle_ilim = (i == 0);
      ff.out_short = (i == 1);
      ff.over_temp = (i == 2);
      ff.open_str = (i == 3) ? 6'h3F : 6'h00;
      repeat (4) @(negedge clk);
      if (i == 0) chk("sw", 16'h0000, 16'(sw_en));
      else chk("run", 16'h0000, 16'(run));
      repeat (300) @(negedge clk);
      ff = '0;
      repeat (5) @(negedge clk);
      chk("run", 16'h0000, 16'(run));
      chk("sw", 16'h0000, 16'(sw_en));
      en = 1'b0;
      repeat (5) @(negedge clk);
      en = 1'b1;
      wait_run();
      chk("active", 16'h003F, 16'(act));
    end
    stop_test();
  end
endmodule
